// ==== hw/cis_core_interrupt_sequencer.sv ====
/*
 * Interrupt sequencer of a small 8-bit core: flags, enables, request
 * gating, vectoring sequence, return handling, sleep wake-up and the
 * edge-selectable external pin.
 * Assumes the core gives one-cycle event pulses on pclk and follows the
 * vectoring commands; peripheral flags arrive as level set pulses.
 */
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - any reset clears all enables, so nothing vectors until software enables.
// - vectoring needs global and own enable; peripheral sources also need periph enable.
// - flags set on their events regardless of every enable bit.
// - on enabled event: flush prefetch, push PC, load 0004h, then clear global enable.
// - flags stay set until software clears; a pending enabled flag retriggers.
// - with global enable clear only flags set and an enabled flag wakes sleep; pending served once re-enabled.
// - return_from_irq pops return address and sets global enable together.
// - synchronous source reaches the vector exactly three instruction cycles later.
// - asynchronous source takes three or four cycles, independent of instruction length.
// - external flag may set during Q4 to Q1 and is sampled at Q1.
// - after wake the next instruction runs, then vector if global enable set; a wake in Q2 to Q4 skips WAKE and a pending request flushes at the next Q1.
// - external pin is edge-triggered; edge select high rising, low falling.
// - a selected edge sets external flag; vectoring needs global and external enable.
// - hardware saves only the return PC; software saves working registers.
// - vectoring loads PC directly and leaves pc_high_latch untouched.
// - irq_control_reg is fully readable and writable with three sources.
// - layout 7 global, 6 periph, timer, ext, port enables, then flags.
module cis_core_interrupt_sequencer
    import cis_pkg::*;
#(
    parameter int PERIPH_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin,
    input wire cis_core_in_t core_in,
    input wire logic [PERIPH_W-1:0] periph_event,
    output cis_core_cmd_t core_cmd,
    output logic irq_pending,
    output logic [1:0] q_phase,
    output logic in_service
);

    initial begin
        if (PERIPH_W < 1 || PERIPH_W > 8) begin
            $error("PERIPH_W must be 1 to 8");
        end
    end

    function automatic logic [31:0] cis_zext(input logic [7:0] v);
        cis_zext = {24'h000000, v};
    endfunction

    logic [7:0] irq_control_reg;
    logic [PERIPH_W-1:0] periph_flag_reg;
    logic [PERIPH_W-1:0] periph_enable_reg;
    logic ext_edge_select;
    cis_phase_t phase;
    cis_seq_t seq;
    logic [1:0] lat_cnt;
    logic asleep;
    logic pin_s1, pin_s2, pin_s3;
    logic ext_latch;

    wire logic wr = psel && penable && pwrite;
    wire logic global_irq_enable = irq_control_reg[CIS_BIT_GIE];
    wire logic periph_irq_enable = irq_control_reg[CIS_BIT_PIE];
    wire logic wr_ctl = wr && paddr == CIS_OFF_CONTROL;

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    always_comb begin
        pslverr = 1'b0;
        prdata = 32'h0000_0000;
        if (psel && penable) begin
            case (paddr)
                CIS_OFF_CONTROL: prdata = cis_zext(irq_control_reg);
                CIS_OFF_PFLAG: prdata = cis_zext(8'(periph_flag_reg));
                CIS_OFF_PENABLE: prdata = cis_zext(8'(periph_enable_reg));
                CIS_OFF_OPTION: prdata = cis_zext({7'h00, ext_edge_select});
                CIS_OFF_STATUS: prdata = cis_zext({3'h0, asleep, seq, phase});
                default: pslverr = 1'b1;
            endcase
        end
    end

    // four-phase instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= CIS_Q1;
        end else begin
            case (phase)
                CIS_Q1: phase <= CIS_Q2;
                CIS_Q2: phase <= CIS_Q3;
                CIS_Q3: phase <= CIS_Q4;
                CIS_Q4: phase <= CIS_Q1;
                default: phase <= CIS_Q1;
            endcase
        end
    end
    assign q_phase = phase;
    wire logic cycle_start = phase == CIS_Q1;

    // pin synchroniser; the second and third stages feed the edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= ext_irq_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    wire logic ext_edge = ext_edge_select ? (pin_s2 && !pin_s3) : (!pin_s2 && pin_s3);

    // edge caught any time, handed to the flag only in the Q4..Q1 window
    wire logic ext_window = phase == CIS_Q4 || phase == CIS_Q1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_latch <= 1'b0;
        end else if (ext_edge && !ext_window) begin
            ext_latch <= 1'b1;
        end else if (ext_window) begin
            ext_latch <= 1'b0;
        end
    end
    wire logic ext_set = ext_window && (ext_edge || ext_latch);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_edge_select <= CIS_EDGE_RST;
        end else if (wr && paddr == CIS_OFF_OPTION) begin
            ext_edge_select <= pwdata[CIS_BIT_EDGE];
        end
    end

    // enables and control flags; hardware set wins over software clear
    logic next_gie;
    always_comb begin
        next_gie = global_irq_enable;
        if (wr_ctl) begin
            next_gie = pwdata[CIS_BIT_GIE];
        end
        if (core_cmd.load_vector) begin
            next_gie = 1'b0;
        end else if (core_in.return_from_irq) begin
            next_gie = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_control_reg <= CIS_CONTROL_RST;
        end else begin
            if (wr_ctl) begin
                irq_control_reg[CIS_BIT_PIE:CIS_BIT_PCF] <= pwdata[CIS_BIT_PIE:CIS_BIT_PCF];
            end
            irq_control_reg[CIS_BIT_GIE] <= next_gie;
            if (core_in.timer_zero_ovf) begin
                irq_control_reg[CIS_BIT_T0F] <= 1'b1;
            end
            if (ext_set) begin
                irq_control_reg[CIS_BIT_EXF] <= 1'b1;
            end
            if (core_in.port_change) begin
                irq_control_reg[CIS_BIT_PCF] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_flag_reg <= PERIPH_W'(CIS_PERIPH_RST);
            periph_enable_reg <= PERIPH_W'(CIS_PERIPH_RST);
        end else begin
            if (wr && paddr == CIS_OFF_PENABLE) begin
                periph_enable_reg <= pwdata[PERIPH_W-1:0];
            end
            if (wr && paddr == CIS_OFF_PFLAG) begin
                periph_flag_reg <= pwdata[PERIPH_W-1:0] | periph_event;
            end else begin
                periph_flag_reg <= periph_flag_reg | periph_event;
            end
        end
    end

    // request gating; unmasked request also drives wake-up
    wire logic core_req = (irq_control_reg[CIS_BIT_T0E] && irq_control_reg[CIS_BIT_T0F])
        || (irq_control_reg[CIS_BIT_EXE] && irq_control_reg[CIS_BIT_EXF])
        || (irq_control_reg[CIS_BIT_PCE] && irq_control_reg[CIS_BIT_PCF]);
    wire logic periph_req = periph_irq_enable && |(periph_flag_reg & periph_enable_reg);
    wire logic enabled_req = core_req || periph_req;
    assign irq_pending = global_irq_enable && enabled_req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asleep <= 1'b0;
        end else if (core_in.sleep_exec) begin
            asleep <= 1'b1;
        end else if (asleep && (core_in.wake_event || enabled_req)) begin
            asleep <= 1'b0;
        end
    end
    wire logic waking = asleep && (core_in.wake_event || enabled_req);

    // vectoring sequence counted in instruction cycles; the event cycle,
    // flush cycle and push cycle make the fixed three-cycle latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq <= CIS_IDLE;
            lat_cnt <= 2'h0;
        end else if (cycle_start) begin
            case (seq)
                CIS_IDLE: begin
                    if (waking) begin
                        seq <= CIS_WAKE;
                    end else if (irq_pending && !asleep) begin
                        seq <= CIS_FLUSH;
                        lat_cnt <= 2'h1;
                    end
                end
                CIS_WAKE: begin
                    seq <= CIS_IDLE; // next instruction runs, then gate re-checked
                end
                CIS_FLUSH: begin
                    seq <= CIS_PUSH;
                    lat_cnt <= lat_cnt + 2'h1;
                end
                CIS_PUSH: begin
                    if (lat_cnt + 2'h1 >= CIS_LAT_CYCLES) begin
                        seq <= CIS_IDLE;
                    end
                    lat_cnt <= lat_cnt + 2'h1;
                end
                default: seq <= CIS_IDLE;
            endcase
        end
    end

    // flush, push_pc and load_vector are one-cycle pulses launched at Q1, pop_pc follows the return; pc_high_latch is never touched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_cmd <= '0;
            in_service <= 1'b0;
        end else begin
            core_cmd.flush <= cycle_start && seq == CIS_IDLE && irq_pending && !asleep && !waking;
            core_cmd.push_pc <= cycle_start && seq == CIS_FLUSH;
            core_cmd.load_vector <= cycle_start && seq == CIS_PUSH;
            core_cmd.vector <= CIS_VECTOR;
            core_cmd.pop_pc <= core_in.return_from_irq;
            if (cycle_start && seq == CIS_PUSH) begin
                in_service <= 1'b1;
            end else if (core_in.return_from_irq) begin
                in_service <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ==== hw/cis_pkg.sv ====
/*
 * Package for the core interrupt sequencer: register map, bit positions,
 * reset values, phase and sequencer encodings, carrier structs.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package cis_pkg;

    // register byte offsets
    localparam logic [7:0] CIS_OFF_CONTROL = 8'h00;
    localparam logic [7:0] CIS_OFF_PFLAG = 8'h04;
    localparam logic [7:0] CIS_OFF_PENABLE = 8'h08;
    localparam logic [7:0] CIS_OFF_OPTION = 8'h0C;
    localparam logic [7:0] CIS_OFF_STATUS = 8'h10;

    // irq_control_reg bit positions
    localparam int CIS_BIT_GIE = 7;
    localparam int CIS_BIT_PIE = 6;
    localparam int CIS_BIT_T0E = 5;
    localparam int CIS_BIT_EXE = 4;
    localparam int CIS_BIT_PCE = 3;
    localparam int CIS_BIT_T0F = 2;
    localparam int CIS_BIT_EXF = 1;
    localparam int CIS_BIT_PCF = 0;

    // option register: edge select
    localparam int CIS_BIT_EDGE = 0;

    localparam logic [7:0] CIS_CONTROL_RST = 8'h00;
    localparam logic [7:0] CIS_PERIPH_RST = 8'h00;
    localparam logic CIS_EDGE_RST = 1'b1;

    localparam logic [15:0] CIS_VECTOR = 16'h0004;
    localparam logic [1:0] CIS_LAT_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        CIS_Q1 = 2'b00,
        CIS_Q2 = 2'b01,
        CIS_Q3 = 2'b11,
        CIS_Q4 = 2'b10
    } cis_phase_t;

    typedef enum logic [1:0] {
        CIS_IDLE = 2'b00,
        CIS_FLUSH = 2'b01,
        CIS_PUSH = 2'b11,
        CIS_WAKE = 2'b10
    } cis_seq_t;

    // core-side event bundle
    typedef struct packed {
        logic timer_zero_ovf;
        logic port_change;
        logic return_from_irq;
        logic sleep_exec;
        logic wake_event;
    } cis_core_in_t;

    // commands from the sequencer to the core
    typedef struct packed {
        logic flush;
        logic push_pc;
        logic load_vector;
        logic [15:0] vector;
        logic pop_pc;
    } cis_core_cmd_t;

endpackage

// ==== dv/cis_seq_properties.sv ====
/* port checks of the interrupt sequencer.
   assumes binding into cis_core_interrupt_sequencer. */
`timescale 1ns/1ns
`default_nettype none
module cis_seq_properties
    import cis_pkg::*;
#(
    parameter int PERIPH_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_irq_pin,
    input wire cis_core_in_t core_in,
    input wire logic [PERIPH_W-1:0] periph_event,
    input wire cis_core_cmd_t core_cmd,
    input wire logic irq_pending,
    input wire logic [1:0] q_phase,
    input wire logic in_service
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    assign acc = psel && penable;
    assign mapped = paddr inside {CIS_OFF_CONTROL, CIS_OFF_PFLAG, CIS_OFF_PENABLE, CIS_OFF_OPTION, CIS_OFF_STATUS};
    sequence s_entry;
        core_cmd.push_pc ##4 core_cmd.load_vector;
    endsequence
    property p_entry; core_cmd.flush |-> ##[1:4] s_entry; endproperty
    property p_vec; core_cmd.load_vector |-> core_cmd.vector == CIS_VECTOR; endproperty
    // global enable drops at the edge that samples load_vector, so look one cycle on
    property p_gie; core_cmd.load_vector |=> !irq_pending; endproperty
    property p_pop; core_in.return_from_irq |=> core_cmd.pop_pc; endproperty
    property p_bus; acc |-> pready && (pslverr == !mapped); endproperty
    property p_idle; !acc |-> prdata == 32'h0; endproperty
    property p_rst; $rose(presetn) |-> !irq_pending; endproperty
    property p_cause; core_cmd.flush |-> $past(irq_pending) || $past(irq_pending, 2); endproperty
    a_entry: assert property (p_entry) else $error("entry steps out of order");
    a_vec: assert property (p_vec) else $error("wrong vector");
    a_gie: assert property (p_gie) else $error("pending at vector load");
    a_pop: assert property (p_pop) else $error("no pop after return");
    a_bus: assert property (p_bus) else $error("bad bus answer");
    a_idle: assert property (p_idle) else $error("read data outside access");
    a_rst: assert property (p_rst) else $error("pending after reset");
    a_cause: assert property (p_cause) else $error("flush without request");
endmodule
bind cis_core_interrupt_sequencer cis_seq_properties #(.PERIPH_W(PERIPH_W)) u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin, .core_in, .periph_event,
    .core_cmd, .irq_pending, .q_phase, .in_service);
`default_nettype wire

// ==== dv/cis_core_model.sv ====
/* core and event source model: bench requests become one-cycle pulses.
   assumes each request lasts one pclk cycle. */
`timescale 1ns/1ns
`default_nettype none
module cis_core_model
    import cis_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire cis_core_in_t req,
    input wire logic [7:0] preq,
    input wire cis_core_cmd_t core_cmd,
    output cis_core_in_t core_in,
    output logic [7:0] periph_event,
    output logic [7:0] vec_count
);
    // bench requests reach the sequencer one pclk later as core events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_in <= '0;
            periph_event <= 8'h00;
        end else begin
            core_in <= req;
            periph_event <= preq;
        end
    end
    // counts the load_vector pulses commanded to the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_count <= 8'h00;
        end else begin
            vec_count <= vec_count + 8'(core_cmd.load_vector);
        end
    end
endmodule
`default_nettype wire

// ==== dv/core_interrupt_sequencer_tb_top.sv ====
/* top bench: apb tasks, event pulses, pin edges.
   assumes the package map and a zero-wait apb slave. */
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_sequencer_tb_top;
    import cis_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic pin = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, irq_pending, in_service, e;
    logic [1:0] q_phase;
    cis_core_in_t req = '0;
    cis_core_in_t core_in;
    logic [7:0] preq = 8'h00;
    logic [7:0] periph_event, vec_count;
    cis_core_cmd_t core_cmd;
    int fail_count = 0;
    int checked = 0;
    int n;
    initial forever #50 pclk = ~pclk;
    cis_core_interrupt_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_irq_pin(pin), .core_in, .periph_event, .core_cmd, .irq_pending, .q_phase,
        .in_service);
    cis_core_model model (.pclk, .presetn, .req, .preq, .core_cmd, .core_in, .periph_event, .vec_count);
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        logic r;
        k = 0;
        r = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer taken from settled values that stand into the sampling edge
        do begin
            @(negedge pclk);
            r = pready;
            q = prdata;
            e = pslverr;
            @(posedge pclk);
            k++;
        end while (r !== 1'b1 && k < 20);
        chk(32'(r), 32'h1);
        if (r !== 1'b1) complete_run();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic pend(input logic x);
        @(negedge pclk);
        chk(32'(irq_pending), 32'(x));
    endtask
    // pulse lasts one cycle; the gap lets the request settle before the next access
    task automatic pulse(input cis_core_in_t r, input logic [7:0] p);
        @(posedge pclk);
        req <= r;
        preq <= p;
        @(posedge pclk);
        req <= '0;
        preq <= 8'h00;
        repeat (4) @(posedge pclk);
    endtask
    task automatic wait_vec(input int hi);
        n = 0;
        // look mid-cycle: the pulse is launched by the edge itself
        while (core_cmd.load_vector !== 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
        end
        chk(32'(n <= hi), 32'h1);
        if (n >= 40) complete_run();
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(CIS_OFF_CONTROL, 32'h0);
        rd(CIS_OFF_OPTION, 32'h1);
        rd(8'h20, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, CIS_OFF_CONTROL, 32'h7F);
        rd(CIS_OFF_CONTROL, 32'h7F);
        apb(1'b1, CIS_OFF_CONTROL, 32'h0);
        pulse(5'b10000, 8'h00);
        rd(CIS_OFF_CONTROL, 32'h04);
        apb(1'b1, CIS_OFF_CONTROL, 32'h24);
        pend(1'b0);
        apb(1'b1, CIS_OFF_CONTROL, 32'hA4);
        pend(1'b1);
        wait_vec(16);
        chk(32'(in_service), 32'h1);
        rd(CIS_OFF_CONTROL, 32'h24);
        pulse(5'b00100, 8'h00);
        wait_vec(30);
        apb(1'b1, CIS_OFF_CONTROL, 32'h20);
        pulse(5'b00100, 8'h00);
        rd(CIS_OFF_CONTROL, 32'hA0);
        pend(1'b0);
        apb(1'b1, CIS_OFF_CONTROL, 32'h0);
        pulse('0, 8'h01);
        rd(CIS_OFF_PFLAG, 32'h01);
        apb(1'b1, CIS_OFF_PENABLE, 32'h01);
        apb(1'b1, CIS_OFF_CONTROL, 32'h80);
        pend(1'b0);
        apb(1'b1, CIS_OFF_CONTROL, 32'hC0);
        pend(1'b1);
        wait_vec(16);
        rd(CIS_OFF_CONTROL, 32'h40);
        apb(1'b1, CIS_OFF_PFLAG, 32'h0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, CIS_OFF_OPTION, 32'(i == 0));
            apb(1'b1, CIS_OFF_CONTROL, 32'h0);
            @(posedge pclk);
            pin <= (i != 1);
            repeat (10) @(posedge pclk);
            rd(CIS_OFF_CONTROL, (i < 2) ? 32'h02 : 32'h0);
        end
        apb(1'b1, CIS_OFF_CONTROL, 32'h90);
        @(posedge pclk);
        pin <= 1'b0;
        wait_vec(24);
        apb(1'b1, CIS_OFF_CONTROL, 32'h20);
        pulse(5'b00010, 8'h00);
        apb(1'b0, CIS_OFF_STATUS, 32'h0);
        chk(q & 32'h10, 32'h10);
        pulse(5'b10000, 8'h00);
        apb(1'b0, CIS_OFF_STATUS, 32'h0);
        chk(q & 32'h10, 32'h0);
        rd(CIS_OFF_CONTROL, 32'h24);
        chk(32'(vec_count), 32'h4);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CIS_OFF_CONTROL, 32'h0);
        chk(32'(in_service), 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
